/* hdl/tsrm_pkg.sv */
// Register map constants for the touch sensor register bank.
// Assumes byte-wide registers on an 8-bit address space.
package tsrm_pkg;

   // Sizes
   localparam int TSRM_NUM_INPUTS = 6;
   localparam int TSRM_NUM_RW = 25;

   // Index of each read-write register in the storage array
   localparam int IDX_POWER = 0;
   localparam int IDX_SCALING = 1;
   localparam int IDX_CONFIG = 2;
   localparam int IDX_SAMPLE_EN = 3;
   localparam int IDX_DURATION = 4;
   localparam int IDX_MIN_PRESS = 5;
   localparam int IDX_AVERAGING = 6;
   localparam int IDX_RECAL = 7;
   localparam int IDX_IRQ_EN = 8;
   localparam int IDX_REPEAT_EN = 9;
   localparam int IDX_MULTI = 10;
   localparam int IDX_PAT_CFG = 11;
   localparam int IDX_PAT_SEL = 12;
   localparam int IDX_RECAL_CFG = 13;
   localparam int IDX_THRESH0 = 14;
   localparam int IDX_NOISE_TH = 20;
   localparam int IDX_STBY_SEL = 21;
   localparam int IDX_STBY_TIME = 22;
   localparam int IDX_STBY_GAIN = 23;
   localparam int IDX_STBY_TH = 24;

   // Byte address of each read-write register
   localparam logic [7:0] RW_ADDR [TSRM_NUM_RW] = '{
      8'h00, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h28,
      8'h2a, 8'h2b, 8'h2d, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
      8'h38, 8'h40, 8'h41, 8'h42, 8'h43};

   // Value after reset of each read-write register
   localparam logic [7:0] RW_RESET [TSRM_NUM_RW] = '{
      8'h00, 8'h2f, 8'h20, 8'h3f, 8'ha4, 8'h07, 8'h39, 8'h00, 8'h3f, 8'h3f,
      8'h80, 8'h00, 8'h3f, 8'h8a, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40,
      8'h01, 8'h00, 8'h39, 8'h02, 8'h40};

   // Implemented bits; unused bits are held at zero
   localparam logic [7:0] RW_MASK [TSRM_NUM_RW] = '{
      8'hf1, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

   // Read-only register addresses, masks and reset value
   localparam logic [7:0] ADDR_GEN_STATUS = 8'h02;
   localparam logic [7:0] ADDR_TOUCH_STATUS = 8'h03;
   localparam logic [7:0] ADDR_NOISE_FLAGS = 8'h0a;
   localparam logic [7:0] ADDR_DELTA_BASE = 8'h10;
   localparam logic [7:0] MASK_GEN_STATUS = 8'h07;
   localparam logic [7:0] MASK_INPUTS = 8'h3f;
   localparam logic [7:0] RO_RESET = 8'h00;
   localparam logic [7:0] UNDEF_READ = 8'h00;

   // Field positions in the power-state control register
   localparam int POWER_INT_BIT = 0;
   localparam int POWER_DSLEEP_BIT = 4;

endpackage

/* hdl/tsrm_byte_reg.sv */
// One byte-wide read-write register with hardware set and clear.
// Assumes write strobe and hardware strobes come from the CLK domain.
`timescale 1ns/100ps
`default_nettype none

module tsrm_byte_reg
   import tsrm_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] KEEP_MASK = 8'hff
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   input wire logic [7:0] hw_set,
   input wire logic [7:0] hw_clr,
   output logic [7:0] q
);

   logic [7:0] next_q;

   // Host write beats hardware clear, hardware set beats both
   always_comb begin
      if (wr_en) begin
         next_q = wdata | hw_set;
      end else begin
         next_q = (q & ~hw_clr) | hw_set;
      end
   end

   // Storage with default after reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= RESET_VALUE; // RULE_24
      end else begin
         q <= next_q & KEEP_MASK; // RULE_01
      end
   end

   // Unused bits never show
   AST_UNUSED_BITS_ZERO: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
      wr_en |=> ((q & ~KEEP_MASK) == 8'h00))
      else $error("unused register bits not zero");

endmodule
`default_nettype wire

/* hdl/tsrm_regbank.sv */
// Host-visible register bank of the six-input touch controller.
// Assumes a serial front end on CLK presents byte reads and writes,
// and the sensing core on CLK supplies status, deltas and strobes.
//
// What this block does
// RULE_01 - Unused register bits always read back as zero.
// RULE_02 - Every register is reachable at its byte address via the host port.
// RULE_03 - Power-state control at 00h, read-write, resets to 00h.
// RULE_04 - General status 02h and per-input touch status 03h, read-only, zero.
// RULE_05 - Per-input noise flags at 0Ah, read-only, reset zero.
// RULE_06 - Six read-only delta counts at 10h through 15h, reset zero.
// RULE_07 - Count scaling register at 1Fh, read-write, resets to 2Fh.
// RULE_08 - General configuration at 20h, read-write, resets to 20h.
// RULE_09 - Sample enables at 21h, read-write, reset 3Fh enabling all six.
// RULE_10 - Max duration and repeat delay at 22h, resets to A4h.
// RULE_11 - Minimum press timer at 23h, resets to 07h.
// RULE_12 - Active averaging and sampling window at 24h, resets to 39h.
// RULE_13 - Writing 26h forces recalibration of chosen inputs; resets 00h.
// RULE_14 - Interrupt enables at 27h, repeat enables at 28h, both 3Fh.
// RULE_15 - Multiple-touch count at 2Ah, resets to 80h.
// RULE_16 - Pattern configuration 2Bh resets 00h; pattern select 2Dh resets 3Fh.
// RULE_17 - Recalibration timing at 2Fh, resets to 8Ah.
// RULE_18 - Six touch thresholds at 30h through 35h, each reset 40h.
// RULE_19 - Noise threshold for all inputs at 38h, resets to 01h.
// RULE_20 - Standby input select at 40h, resets to 00h.
// RULE_21 - Standby timing 41h resets 39h; standby gain 42h resets 02h.
// RULE_22 - Standby touch threshold at 43h, resets to 40h.
// RULE_23 - Undefined addresses read 00h and ignore writes.
// RULE_24 - All registers take their defaults during reset.
// RULE_25 - Host writes to read-only registers are ignored.
`timescale 1ns/100ps
`default_nettype none

module tsrm_regbank
   import tsrm_pkg::*;
#(
   parameter int NUM_INPUTS = TSRM_NUM_INPUTS
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic [2:0] CORE_GEN_STATUS,
   input wire logic [NUM_INPUTS-1:0] CORE_TOUCH_STATUS,
   input wire logic [NUM_INPUTS-1:0] CORE_NOISE_FLAGS,
   input wire logic [8*NUM_INPUTS-1:0] CORE_DELTA,
   input wire logic CORE_INT_SET,
   input wire logic [NUM_INPUTS-1:0] CORE_RECAL_DONE,
   output logic [7:0] POWER_CTRL,
   output logic [7:0] COUNT_SCALING,
   output logic [7:0] GENERAL_CONFIG,
   output logic [7:0] SAMPLE_ENABLE,
   output logic [7:0] DURATION_REPEAT,
   output logic [7:0] MIN_PRESS_TIMER,
   output logic [7:0] AVG_SAMPLING,
   output logic [7:0] FORCE_RECAL,
   output logic [7:0] IRQ_ENABLE,
   output logic [7:0] REPEAT_ENABLE,
   output logic [7:0] MULTI_TOUCH_CFG,
   output logic [7:0] PATTERN_CFG,
   output logic [7:0] PATTERN_SELECT,
   output logic [7:0] RECAL_CFG,
   output logic [8*NUM_INPUTS-1:0] TOUCH_THRESHOLD,
   output logic [7:0] NOISE_THRESHOLD,
   output logic [7:0] STANDBY_SELECT,
   output logic [7:0] STANDBY_TIMING,
   output logic [7:0] STANDBY_GAIN,
   output logic [7:0] STANDBY_THRESHOLD
);

   // Read-write storage and read-only captures
   logic [7:0] rw_q [TSRM_NUM_RW];
   logic [7:0] gen_status;
   logic [7:0] touch_status;
   logic [7:0] noise_flags;
   logic [7:0] delta [NUM_INPUTS];
   logic deep_sleep;
   logic [7:0] power_set;
   logic [7:0] power_clr;
   logic [7:0] recal_clr;

   // Address matches a given read-write register
   function automatic logic rw_hit(input logic [7:0] addr, input int idx);
      rw_hit = (addr == RW_ADDR[idx]);
   endfunction

   // Address falls in the delta count window
   function automatic logic delta_hit(input logic [7:0] addr);
      delta_hit = (addr >= ADDR_DELTA_BASE) &&
                  (addr < ADDR_DELTA_BASE + 8'(NUM_INPUTS));
   endfunction

   // Read multiplexer over the whole map
   function automatic logic [7:0] read_byte(input logic [7:0] addr);
      logic [7:0] val;
      logic [7:0] off;
      val = UNDEF_READ; // RULE_23
      off = addr - ADDR_DELTA_BASE;
      for (int i = 0; i < TSRM_NUM_RW; i++) begin
         if (rw_hit(addr, i)) begin
            val = rw_q[i]; // RULE_02
         end
      end
      if (addr == ADDR_GEN_STATUS) begin
         val = gen_status; // RULE_04
      end
      if (addr == ADDR_TOUCH_STATUS) begin
         val = touch_status; // RULE_04
      end
      if (addr == ADDR_NOISE_FLAGS) begin
         val = noise_flags; // RULE_05
      end
      if (delta_hit(addr)) begin
         val = delta[off[2:0]]; // RULE_06
      end
      read_byte = val;
   endfunction

   // Hardware-driven bits of power control and recalibration
   assign deep_sleep = rw_q[IDX_POWER][POWER_DSLEEP_BIT];
   assign power_set = {7'h00, CORE_INT_SET};
   assign power_clr = {7'h00, deep_sleep};
   assign recal_clr = 8'(CORE_RECAL_DONE);

   // One register instance per read-write address
   generate
      for (genvar g = 0; g < TSRM_NUM_RW; g++) begin : g_rw
         logic [7:0] set_bits;
         logic [7:0] clr_bits;
         if (g == IDX_POWER) begin : g_power
            assign set_bits = power_set; // RULE_03
            assign clr_bits = power_clr;
         end else if (g == IDX_RECAL) begin : g_recal
            assign set_bits = 8'h00;
            assign clr_bits = recal_clr; // RULE_13
         end else begin : g_plain
            assign set_bits = 8'h00;
            assign clr_bits = 8'h00;
         end
         tsrm_byte_reg #(
            .RESET_VALUE(RW_RESET[g]),
            .KEEP_MASK(RW_MASK[g])
         ) u_reg (
            .clk(CLK),
            .resetn(RESETN),
            .wr_en(REG_WR && rw_hit(REG_ADDR, g)), // RULE_23
            .wdata(REG_WDATA),
            .hw_set(set_bits),
            .hw_clr(clr_bits),
            .q(rw_q[g])
         );
      end
   endgenerate

   // Status captures; deep sleep clears them, host writes never reach them
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         gen_status <= RO_RESET; // RULE_24
         touch_status <= RO_RESET;
         noise_flags <= RO_RESET;
      end else if (deep_sleep) begin
         gen_status <= RO_RESET;
         touch_status <= RO_RESET;
         noise_flags <= RO_RESET;
      end else begin
         gen_status <= 8'(CORE_GEN_STATUS) & MASK_GEN_STATUS; // RULE_25
         touch_status <= 8'(CORE_TOUCH_STATUS) & MASK_INPUTS; // RULE_01
         noise_flags <= 8'(CORE_NOISE_FLAGS) & MASK_INPUTS; // RULE_05
      end
   end

   // Delta count captures, one byte per input
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            delta[i] <= RO_RESET; // RULE_06
         end
      end else begin
         for (int i = 0; i < NUM_INPUTS; i++) begin
            delta[i] <= CORE_DELTA[8*i +: 8];
         end
      end
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         REG_RDATA <= UNDEF_READ;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= read_byte(REG_ADDR); // RULE_02
         end
      end
   end

   // Configuration outputs straight from storage
   assign POWER_CTRL = rw_q[IDX_POWER]; // RULE_03
   assign COUNT_SCALING = rw_q[IDX_SCALING]; // RULE_07
   assign GENERAL_CONFIG = rw_q[IDX_CONFIG]; // RULE_08
   assign SAMPLE_ENABLE = rw_q[IDX_SAMPLE_EN]; // RULE_09
   assign DURATION_REPEAT = rw_q[IDX_DURATION]; // RULE_10
   assign MIN_PRESS_TIMER = rw_q[IDX_MIN_PRESS]; // RULE_11
   assign AVG_SAMPLING = rw_q[IDX_AVERAGING]; // RULE_12
   assign FORCE_RECAL = rw_q[IDX_RECAL]; // RULE_13
   assign IRQ_ENABLE = rw_q[IDX_IRQ_EN]; // RULE_14
   assign REPEAT_ENABLE = rw_q[IDX_REPEAT_EN]; // RULE_14
   assign MULTI_TOUCH_CFG = rw_q[IDX_MULTI]; // RULE_15
   assign PATTERN_CFG = rw_q[IDX_PAT_CFG]; // RULE_16
   assign PATTERN_SELECT = rw_q[IDX_PAT_SEL]; // RULE_16
   assign RECAL_CFG = rw_q[IDX_RECAL_CFG]; // RULE_17
   assign NOISE_THRESHOLD = rw_q[IDX_NOISE_TH]; // RULE_19
   assign STANDBY_SELECT = rw_q[IDX_STBY_SEL]; // RULE_20
   assign STANDBY_TIMING = rw_q[IDX_STBY_TIME]; // RULE_21
   assign STANDBY_GAIN = rw_q[IDX_STBY_GAIN]; // RULE_21
   assign STANDBY_THRESHOLD = rw_q[IDX_STBY_TH]; // RULE_22

   // Per-input thresholds packed side by side
   generate
      for (genvar t = 0; t < NUM_INPUTS; t++) begin : g_thresh
         assign TOUCH_THRESHOLD[8*t +: 8] = rw_q[IDX_THRESH0 + t]; // RULE_18
      end
   endgenerate

   // Checks on the register bank
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   // Host transactions
   sequence s_write(logic [7:0] a);
      REG_WR && (REG_ADDR == a);
   endsequence

   sequence s_read(logic [7:0] a);
      REG_RD && !REG_WR && (REG_ADDR == a);
   endsequence

   AST_READ_ANSWER_ONE_CYCLE: assert property ( // RULE_02
      REG_RD |=> REG_RVALID)
      else $error("read answer not one cycle after strobe");

   AST_UNDEF_READS_ZERO: assert property ( // RULE_23
      (REG_RD && (REG_ADDR == 8'h01 || REG_ADDR == 8'h25 || REG_ADDR == 8'h44))
      |=> (REG_RDATA == 8'h00))
      else $error("undefined address read not zero");

   AST_POWER_UNUSED_ZERO: assert property ( // RULE_01
      s_read(8'h00) |=> (REG_RDATA[3:1] == 3'h0))
      else $error("unused power control bits read nonzero");

   AST_RESET_DEFAULTS: assert property (@(posedge CLK) disable iff (1'b0) // RULE_24
      !RESETN |=> (SAMPLE_ENABLE == 8'h3f) && (DURATION_REPEAT == 8'ha4) &&
                  (RECAL_CFG == 8'h8a) && (TOUCH_THRESHOLD[7:0] == 8'h40) &&
                  (STANDBY_GAIN == 8'h02) && (MULTI_TOUCH_CFG == 8'h80))
      else $error("register default after reset wrong");

   AST_WRITE_READBACK: assert property ( // RULE_22
      s_write(8'h43) ##1 s_read(8'h43) |=> (REG_RDATA == $past(REG_WDATA, 2)))
      else $error("standby threshold readback mismatch");

   AST_SAMPLE_ENABLE_WRITE: assert property ( // RULE_09
      s_write(8'h21) |=> (SAMPLE_ENABLE == $past(REG_WDATA)))
      else $error("sample enable write not taken");

   AST_INT_SET_WINS: assert property ( // RULE_03
      CORE_INT_SET |=> POWER_CTRL[POWER_INT_BIT])
      else $error("interrupt flag lost against clear");

   AST_RECAL_HELD: assert property ( // RULE_13
      s_write(8'h26) ##0 REG_WDATA[0] ##1 (!CORE_RECAL_DONE[0] && !REG_WR)[*2]
      |=> FORCE_RECAL[0])
      else $error("recalibration request dropped early");

   AST_RO_WRITE_IGNORED: assert property ( // RULE_25
      s_write(8'h10) ##0 !deep_sleep |=> (delta[0] == $past(CORE_DELTA[7:0])))
      else $error("write disturbed a read-only register");

   AST_DELTA_READ: assert property ( // RULE_06
      s_read(8'h15) |=> (REG_RDATA == $past(delta[5])))
      else $error("delta count read wrong");

endmodule
`default_nettype wire

/* testbench/tsrm_host.sv */
// Host model of the byte-wide register port of the touch register bank.
// Assumes its tasks are called one at a time from a single process.
`timescale 1ns/100ps
`default_nettype none

module tsrm_host (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd
);
   // Idle port at time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end

   // One-cycle write strobe; lines scrambled once released
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask

   // One-cycle read strobe; answer is picked up by the bench monitor
   task automatic read_byte(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
   endtask

   // Write then read the same byte on back-to-back edges
   task automatic write_read(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
endmodule

`default_nettype wire

/* testbench/tb_touch_sensor_register_map.sv */
// Self-checking bench for the touch register bank.
// Assumes the host model drives the port and a monitor checks read data.
`timescale 1ns/100ps
`default_nettype none

module tb_touch_sensor_register_map;
   import tsrm_pkg::*;
   localparam logic [7:0] UNDEF [4] = '{8'h01, 8'h29, 8'h44, 8'hfe};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic reg_wr, reg_rd, reg_rvalid, int_set = 1'b0;
   logic [2:0] gen_st = 3'h0;
   logic [5:0] touch_st = 6'h00, noise_st = 6'h00, recal_done = 6'h00;
   logic [47:0] delta = 48'h0;
   logic [63:0] r64;
   logic [7:0] exp_q[$];
   logic [7:0] wr_exp [TSRM_NUM_RW];
   wire [7:0] cfg [TSRM_NUM_RW];
   wire [47:0] thr;
   int failures = 0;
   int checks = 0;
   int i;

   tsrm_host host (.clk(clk), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd));

   tsrm_regbank i_tsrm_regbank (.CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .CORE_GEN_STATUS(gen_st), .CORE_TOUCH_STATUS(touch_st),
      .CORE_NOISE_FLAGS(noise_st), .CORE_DELTA(delta), .CORE_INT_SET(int_set),
      .CORE_RECAL_DONE(recal_done), .POWER_CTRL(cfg[0]), .COUNT_SCALING(cfg[1]),
      .GENERAL_CONFIG(cfg[2]), .SAMPLE_ENABLE(cfg[3]), .DURATION_REPEAT(cfg[4]),
      .MIN_PRESS_TIMER(cfg[5]), .AVG_SAMPLING(cfg[6]), .FORCE_RECAL(cfg[7]),
      .IRQ_ENABLE(cfg[8]), .REPEAT_ENABLE(cfg[9]), .MULTI_TOUCH_CFG(cfg[10]),
      .PATTERN_CFG(cfg[11]), .PATTERN_SELECT(cfg[12]), .RECAL_CFG(cfg[13]),
      .TOUCH_THRESHOLD(thr), .NOISE_THRESHOLD(cfg[20]), .STANDBY_SELECT(cfg[21]),
      .STANDBY_TIMING(cfg[22]), .STANDBY_GAIN(cfg[23]), .STANDBY_THRESHOLD(cfg[24]));

   // Thresholds unpacked into the same order as the storage index
   for (genvar g = 0; g < 6; g++) begin : g_thr
      assign cfg[IDX_THRESH0 + g] = thr[8*g +: 8];
   end

   // Free-running 100 MHz clock
   initial forever #5 clk = ~clk;

   // Read data comparison
   task automatic compare(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Note the expected answer, then issue the read
   task automatic read_check(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.read_byte(a);
   endtask

   // Verdict and end of run
   task automatic complete_run;
      if (exp_q.size() != 0)
         failures++;
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Monitor takes the oldest note whenever read data appears
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("mismatch %0t got %h expected none", $time, reg_rdata);
         end else begin
            compare(reg_rdata, exp_q.pop_front());
         end
      end
   end

   // Watchdog against a hung port
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run();
   end

   // Main sequence
   initial begin
      v = 8'($urandom(33563));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      // Defaults after reset
      for (i = 0; i < 7; i++)
         read_check(RW_ADDR[i], RW_RESET[i]);
      for (i = 7; i < 14; i++)
         read_check(RW_ADDR[i], RW_RESET[i]);
      for (i = 14; i < TSRM_NUM_RW; i++)
         read_check(RW_ADDR[i], RW_RESET[i]);
      for (i = 0; i < 6; i++)
         read_check(ADDR_DELTA_BASE + 8'(i), 8'h00);
      for (i = 0; i < TSRM_NUM_RW; i++)
         compare(cfg[i], RW_RESET[i]);
      // Random write and read back, unused bits read zero
      for (i = 0; i < TSRM_NUM_RW; i++) begin
         v = 8'($urandom);
         if (i == IDX_POWER)
            v[4] = 1'b0;
         host.write_byte(RW_ADDR[i], v);
         wr_exp[i] = v & RW_MASK[i];
         read_check(RW_ADDR[i], wr_exp[i]);
      end
      for (i = 0; i < TSRM_NUM_RW; i++)
         compare(cfg[i], wr_exp[i]);
      // Back-to-back write and read of the standby threshold
      v = 8'($urandom);
      exp_q.push_back(v);
      host.write_read(8'h43, v);
      // Core status captured; host writes to read-only places ignored
      r64 = {$urandom, $urandom};
      {delta, gen_st, touch_st, noise_st} <= r64[62:0];
      host.write_byte(ADDR_GEN_STATUS, 8'hff);
      host.write_byte(ADDR_TOUCH_STATUS, 8'hff);
      host.write_byte(ADDR_DELTA_BASE, 8'hff);
      read_check(ADDR_GEN_STATUS, {5'h00, gen_st});
      read_check(ADDR_TOUCH_STATUS, {2'h0, touch_st});
      read_check(ADDR_NOISE_FLAGS, {2'h0, noise_st});
      for (i = 0; i < 6; i++)
         read_check(ADDR_DELTA_BASE + 8'(i), delta[8*i +: 8]);
      // Undefined addresses
      for (i = 0; i < 4; i++) begin
         host.write_byte(UNDEF[i], 8'hff);
         read_check(UNDEF[i], 8'h00);
      end
      // Forced recalibration cleared per input on completion
      host.write_byte(8'h26, 8'h3f);
      repeat (3) @(posedge clk);
      recal_done <= 6'h01;
      @(posedge clk);
      recal_done <= 6'h00;
      read_check(8'h26, 8'h3e);
      // Interrupt flag set by core, then deep sleep clears flag and status
      int_set <= 1'b1;
      host.write_byte(8'h00, 8'h00);
      int_set <= 1'b0;
      read_check(8'h00, 8'h01);
      touch_st <= 6'h2a;
      host.write_byte(8'h00, 8'h11);
      read_check(ADDR_TOUCH_STATUS, 8'h00);
      read_check(8'h00, 8'h10);
      // Second reset in mid-run restores defaults
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      read_check(8'h21, 8'h3f);
      read_check(8'h00, 8'h00);
      repeat (3) @(posedge clk);
      complete_run();
   end
endmodule

`default_nettype wire
